// ### core/input_sync.sv
// Two-flop synchroniser for a bundle of asynchronous pins.
// Assumes the pins are slow compared with the clock.
module input_sync
    import mis_pkg::*;
#(
    parameter int W = 1,
    parameter logic [W-1:0] RESET_VAL = '0
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] meta_reg;

    // First stage feeds only the second stage
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            meta_reg <= RESET_VAL;
            dout <= RESET_VAL;
        end else begin
            meta_reg <= din;
            dout <= meta_reg;
        end
    end
endmodule

// ### core/mis_pkg.sv
// Constants, register map and pin bundle for the motion input supervisor.
// Assumes one 20 MHz clock and an Avalon-MM master with byte addresses.
package mis_pkg;
    localparam int AXES = 8;
    localparam int GEN = 16;
    localparam int ADDR_W = 8;
    localparam int LATCH_HI_AXES = 4;
    localparam int LATCH_HI_BASE = 8;

    localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] REG_POLARITY = 8'h04;
    localparam logic [ADDR_W-1:0] REG_COMMAND = 8'h08;
    localparam logic [ADDR_W-1:0] REG_INPUTS = 8'h0c;
    localparam logic [ADDR_W-1:0] REG_SWITCHES = 8'h10;
    localparam logic [ADDR_W-1:0] REG_IRQ_STATUS = 8'h14;
    localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 8'h18;
    localparam logic [ADDR_W-1:0] REG_LATCH_STATUS = 8'h1c;
    localparam logic [2:0] REG_LATCH_POS_BLOCK = 3'h1;

    localparam int CTRL_LATCH_EN = 0;
    localparam int POL_LIMIT_HIGH = 0;
    localparam int POL_HOME_HIGH = 1;
    localparam logic [1:0] CTRL_RESET = 2'h0;
    localparam logic [1:0] POL_RESET = 2'h0;

    localparam int CMD_OP_LSB = 8;
    localparam logic [3:0] OP_HOMING = 4'h1;
    localparam logic [3:0] OP_FIND_EDGE = 4'h2;
    localparam logic [3:0] OP_BEGIN = 4'h3;
    localparam logic [3:0] OP_ARM_LATCH = 4'h4;
    localparam logic [3:0] OP_SAVE = 4'h5;

    localparam int IRQ_W = 5;
    localparam int IRQ_ABORT = 0;
    localparam int IRQ_LIMIT = 1;
    localparam int IRQ_INPUT = 2;
    localparam int IRQ_LATCH = 3;
    localparam int IRQ_HOME = 4;

    typedef enum logic [2:0] {
        AX_IDLE = 3'b001,
        AX_ARMED = 3'b010,
        AX_SLEW = 3'b100
    } axis_state_e;

    typedef struct packed {
        logic abortN;
        logic resetN;
        logic [AXES-1:0] fwd;
        logic [AXES-1:0] rev;
        logic [AXES-1:0] home;
        logic [GEN-1:0] gen;
    } pins_s;

    localparam pins_s PINS_RESET = '{abortN: 1'b1, resetN: 1'b1, fwd: '0, rev: '0,
                                     home: '0, gen: '0};
endpackage

// ### core/motion_input_supervisor.sv
// Discrete input supervisor: abort, reset, limits, home, general inputs, latches.
// Assumes pins are asynchronous, axis positions come from the clk domain.
// Function
// - A low abort halts all motion at once without a ramp and ends the program.
// - A low reset pin returns the processing state to its power-on condition.
// - A pin reset reloads the last saved configuration instead of defaults.
// - An active forward limit blocks forward motion of its axis.
// - An active reverse limit blocks reverse motion of its axis.
// - Any limit becoming active starts the limit switch routine.
// - Limit polarity is set by configuration and the inhibit follows it.
// - Begin motion after a homing or find edge command drives the axis to slew speed.
// - A home input transition during such a move decelerates the axis to a stop.
// - Home polarity is set by the same polarity configuration.
// - General inputs are readable by the program and changes raise an interrupt.
// - With latching enabled general inputs 1 to 4 trigger latches of axes 1 to 4.
// - An armed latch captures its axis position when its trigger occurs.
// - General inputs 9 to 12 trigger latches of axes 5 to 8.
//
// Chosen here: the register offsets and the Avalon-MM slave port.
module motion_input_supervisor
    import mis_pkg::*;
#(
    parameter int POS_W = 32
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    output logic irq,
    input wire pins_s pinsIn,
    input wire logic [AXES*POS_W-1:0] axisPos,
    output logic haltAll,
    output logic programAbort,
    output logic coreResetN,
    output logic [AXES-1:0] fwdInhibit,
    output logic [AXES-1:0] revInhibit,
    output logic limitRoutineStart,
    output logic [AXES-1:0] slewRequest,
    output logic [AXES-1:0] homeStop
);
    pins_s pins;
    pins_s prev_reg;
    logic [1:0] ctrl_reg;
    logic [1:0] pol_reg;
    logic [1:0] savedCtrl_reg;
    logic [1:0] savedPol_reg;
    logic [IRQ_W-1:0] irqStatus_reg;
    logic [IRQ_W-1:0] irqMask_reg;
    logic [IRQ_W-1:0] irqEvent;
    logic [AXES-1:0] latchArmed_reg;
    logic [AXES-1:0] latchDone_reg;
    logic [POS_W-1:0] latchPos_reg [AXES];
    logic [AXES-1:0] latchTrig;
    logic [AXES-1:0] latchFire;
    logic [AXES-1:0] fwdActive;
    logic [AXES-1:0] revActive;
    logic [AXES-1:0] homeActive;
    logic [AXES-1:0] homeEdge;
    logic [AXES-1:0] stopNow;
    logic wrAccess;
    logic rdStart;
    logic cmdWrite;
    logic pinReset;
    logic abortNow;
    logic [3:0] cmdOp;
    logic [AXES-1:0] cmdMask;
    logic [31:0] rdMux;

    input_sync #(
        .W($bits(pins_s)),
        .RESET_VAL(PINS_RESET)
    ) u_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .din(pinsIn),
        .dout(pins)
    );

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            prev_reg <= PINS_RESET;
        end else begin
            prev_reg <= pins;
        end
    end

    assign pinReset = !pins.resetN;
    assign abortNow = !pins.abortN;
    // Polarity bit set means the switch is active when high
    assign fwdActive = pins.fwd ^ {AXES{!pol_reg[POL_LIMIT_HIGH]}};
    assign revActive = pins.rev ^ {AXES{!pol_reg[POL_LIMIT_HIGH]}};
    assign homeActive = pins.home ^ {AXES{!pol_reg[POL_HOME_HIGH]}};
    assign homeEdge = pins.home ^ prev_reg.home;

    // Bus slave: one wait cycle, then the access completes
    assign wrAccess = write && !waitrequest;
    assign rdStart = read && waitrequest;
    assign cmdWrite = wrAccess && (address == REG_COMMAND);
    assign cmdOp = writedata[CMD_OP_LSB +: 4];
    assign cmdMask = writedata[AXES-1:0];

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            waitrequest <= 1'b1;
        end else if ((read || write) && waitrequest) begin
            waitrequest <= 1'b0;
        end else begin
            waitrequest <= 1'b1;
        end
    end

    always_comb begin
        rdMux = 32'h0;
        if (address[7:5] == REG_LATCH_POS_BLOCK) begin
            rdMux[POS_W-1:0] = latchPos_reg[address[4:2]];
        end else begin
            unique case (address)
                REG_CTRL: rdMux[1:0] = ctrl_reg;
                REG_POLARITY: rdMux[1:0] = pol_reg;
                REG_INPUTS: rdMux[GEN-1:0] = pins.gen;
                REG_SWITCHES: rdMux = {homeActive, revActive, fwdActive, abortNow,
                                       pinReset, 6'h00};
                REG_IRQ_STATUS: rdMux[IRQ_W-1:0] = irqStatus_reg;
                REG_IRQ_MASK: rdMux[IRQ_W-1:0] = irqMask_reg;
                REG_LATCH_STATUS: rdMux = {16'h0000, latchArmed_reg, latchDone_reg};
                default: rdMux = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            readdata <= 32'h0;
        end else if (rdStart) begin
            readdata <= rdMux;
        end
    end

    // Working configuration; a pin reset reloads the saved copy
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctrl_reg <= CTRL_RESET;
            pol_reg <= POL_RESET;
        end else if (pinReset) begin
            ctrl_reg <= savedCtrl_reg;
            pol_reg <= savedPol_reg;
        end else if (wrAccess && address == REG_CTRL) begin
            ctrl_reg <= writedata[1:0];
        end else if (wrAccess && address == REG_POLARITY) begin
            pol_reg <= writedata[1:0];
        end
    end

    // Saved copy survives a pin reset, only power-on clears it
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            savedCtrl_reg <= CTRL_RESET;
            savedPol_reg <= POL_RESET;
        end else if (cmdWrite && cmdOp == OP_SAVE) begin
            savedCtrl_reg <= ctrl_reg;
            savedPol_reg <= pol_reg;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            haltAll <= 1'b0;
            programAbort <= 1'b0;
            coreResetN <= 1'b1;
        end else begin
            haltAll <= abortNow;
            programAbort <= abortNow && prev_reg.abortN;
            coreResetN <= !pinReset;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            fwdInhibit <= '0;
            revInhibit <= '0;
            limitRoutineStart <= 1'b0;
        end else begin
            fwdInhibit <= fwdActive;
            revInhibit <= revActive;
            limitRoutineStart <= |((fwdActive & ~fwdInhibit) | (revActive & ~revInhibit));
        end
    end

    // Latch trigger mapping: inputs 1-4 and 9-12, edge towards low level
    genvar i;
    generate
        for (i = 0; i < AXES; i++) begin : g_axis
            axis_state_e axisSt_reg;
            localparam int SRC = (i < LATCH_HI_AXES) ? i : i - LATCH_HI_AXES + LATCH_HI_BASE;
            assign latchTrig[i] = !pins.gen[SRC] && prev_reg.gen[SRC];
            assign latchFire[i] = latchTrig[i] && latchArmed_reg[i] && ctrl_reg[CTRL_LATCH_EN];
            assign stopNow[i] = (axisSt_reg == AX_SLEW) && homeEdge[i];

            always_ff @(posedge clk) begin
                if (sys_rst || pinReset) begin
                    latchArmed_reg[i] <= 1'b0;
                    latchDone_reg[i] <= 1'b0;
                end else if (latchFire[i]) begin
                    latchArmed_reg[i] <= 1'b0;
                    latchDone_reg[i] <= 1'b1;
                end else if (cmdWrite && cmdOp == OP_ARM_LATCH && cmdMask[i]) begin
                    latchArmed_reg[i] <= 1'b1;
                    latchDone_reg[i] <= 1'b0;
                end
            end

            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    latchPos_reg[i] <= '0;
                end else if (latchFire[i]) begin
                    latchPos_reg[i] <= axisPos[i*POS_W +: POS_W];
                end
            end

            always_ff @(posedge clk) begin
                if (sys_rst || pinReset || abortNow) begin
                    axisSt_reg <= AX_IDLE;
                end else begin
                    unique case (axisSt_reg)
                        AX_IDLE: begin
                            if (cmdWrite && cmdMask[i] &&
                                (cmdOp == OP_HOMING || cmdOp == OP_FIND_EDGE)) begin
                                axisSt_reg <= AX_ARMED;
                            end
                        end
                        AX_ARMED: begin
                            if (cmdWrite && cmdMask[i] && cmdOp == OP_BEGIN) begin
                                axisSt_reg <= AX_SLEW;
                            end
                        end
                        AX_SLEW: begin
                            if (homeEdge[i]) begin
                                axisSt_reg <= AX_IDLE;
                            end
                        end
                        default: axisSt_reg <= AX_IDLE;
                    endcase
                end
            end

            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    slewRequest[i] <= 1'b0;
                    homeStop[i] <= 1'b0;
                end else begin
                    slewRequest[i] <= (axisSt_reg == AX_SLEW) && !stopNow[i] && !abortNow;
                    homeStop[i] <= stopNow[i] && !abortNow && !pinReset;
                end
            end
        end
    endgenerate

    assign irqEvent[IRQ_ABORT] = abortNow && prev_reg.abortN;
    assign irqEvent[IRQ_LIMIT] = |((fwdActive & ~fwdInhibit) | (revActive & ~revInhibit));
    assign irqEvent[IRQ_INPUT] = |(pins.gen ^ prev_reg.gen);
    assign irqEvent[IRQ_LATCH] = |latchFire;
    assign irqEvent[IRQ_HOME] = |stopNow;

    // Write-one-to-clear; a same-cycle event keeps its bit set
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irqStatus_reg <= '0;
        end else if (wrAccess && address == REG_IRQ_STATUS) begin
            irqStatus_reg <= (irqStatus_reg & ~writedata[IRQ_W-1:0]) | irqEvent;
        end else begin
            irqStatus_reg <= irqStatus_reg | irqEvent;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irqMask_reg <= '0;
        end else if (wrAccess && address == REG_IRQ_MASK) begin
            irqMask_reg <= writedata[IRQ_W-1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irqStatus_reg & irqMask_reg);
        end
    end

    AST_ABORT_HALT: assert property (@(posedge clk) disable iff (sys_rst)
        abortNow |=> haltAll && slewRequest == '0)
        else $error("abort did not halt motion");

    AST_ABORT_PROG: assert property (@(posedge clk) disable iff (sys_rst)
        $fell(pins.abortN) |=> programAbort ##1 !programAbort)
        else $error("program abort pulse wrong");

    AST_PIN_RESET: assert property (@(posedge clk) disable iff (sys_rst)
        pinReset |=> !coreResetN && latchArmed_reg == '0)
        else $error("pin reset did not restore state");

    AST_RESTORE: assert property (@(posedge clk) disable iff (sys_rst)
        pinReset |=> pol_reg == $past(savedPol_reg) && ctrl_reg == $past(savedCtrl_reg))
        else $error("saved configuration not reloaded");

    AST_FWD_INHIBIT: assert property (@(posedge clk) disable iff (sys_rst)
        !sys_rst |=> fwdInhibit == $past(pol_reg[POL_LIMIT_HIGH] ? pins.fwd : ~pins.fwd))
        else $error("forward inhibit wrong");

    AST_REV_INHIBIT: assert property (@(posedge clk) disable iff (sys_rst)
        !sys_rst && revActive != '0 |=> revInhibit != '0)
        else $error("reverse inhibit missing");

    AST_LIMIT_ROUTINE: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(fwdActive[0]) |=> limitRoutineStart)
        else $error("limit routine not started");

    AST_HOME_STOP: assert property (@(posedge clk) disable iff (sys_rst)
        (stopNow[0] && !abortNow && !pinReset) |=> homeStop[0] && !slewRequest[0])
        else $error("home transition did not stop axis");

    AST_SLEW: assert property (@(posedge clk) disable iff (sys_rst)
        (g_axis[0].axisSt_reg == AX_SLEW && !homeEdge[0] && !abortNow) |=> slewRequest[0])
        else $error("slew not requested");

    AST_LATCH_ONCE: assert property (@(posedge clk) disable iff (sys_rst)
        latchFire[0] |=> !latchArmed_reg[0] && latchDone_reg[0]
                         && latchPos_reg[0] == $past(axisPos[POS_W-1:0]))
        else $error("latch capture wrong");

    AST_LATCH_MAP_HI: assert property (@(posedge clk) disable iff (sys_rst)
        (latchArmed_reg[4] && ctrl_reg[CTRL_LATCH_EN] && $fell(pins.gen[8])
         && !pinReset) |=> latchDone_reg[4])
        else $error("input 9 did not latch axis 5");

    AST_INPUT_IRQ: assert property (@(posedge clk) disable iff (sys_rst)
        (pins.gen != prev_reg.gen) |=> irqStatus_reg[IRQ_INPUT])
        else $error("input change not flagged");

    COV_ABORT: cover property (@(posedge clk) disable iff (sys_rst) programAbort);
    COV_HOME: cover property (@(posedge clk) disable iff (sys_rst) |homeStop);
    COV_LATCH: cover property (@(posedge clk) disable iff (sys_rst) |latchFire);
    COV_IRQ: cover property (@(posedge clk) disable iff (sys_rst) $rose(irq));
endmodule

// ### testbench/switch_model.sv
// External limit, home, abort, reset and general input switches.
// Assumes the bench changes pins only through set_pins, right after an edge.
module switch_model
    import mis_pkg::*;
(
    input wire logic clk,
    output pins_s pins
);
    timeunit 1ns;
    timeprecision 1ns;
    initial pins = PINS_RESET;
    // Real switches are asynchronous; changing on the edge keeps runs repeatable
    task automatic set_pins(input pins_s p);
        @(posedge clk);
        pins <= p;
    endtask
endmodule

// ### testbench/testbench.sv
// Self-checking bench for the motion input supervisor.
// Assumes an Avalon-MM slave with waitrequest; pin changes settle within five edges.
module testbench
    import mis_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic [1:0] pol;
        logic [7:0] fwd, rev, expF, expR;
        logic chkL;
    } row_s;
    logic clk, sysRst, read, write, waitrequest, irq, haltAll, programAbort, coreResetN;
    logic limitRoutineStart;
    logic [ADDR_W-1:0] address;
    logic [31:0] writedata, readdata, rdat;
    logic [AXES-1:0] fwdInhibit, revInhibit, slewRequest, homeStop;
    logic [AXES*32-1:0] axisPos;
    pins_s pinsIn, p;
    int err_count, n_compared, nAbort, nLim, nHome;
    row_s rows [4] = '{
        '{2'h0, 8'hff, 8'hff, 8'h00, 8'h00, 1'b0},
        '{2'h0, 8'hfe, 8'h7f, 8'h01, 8'h80, 1'b1},
        '{2'h1, 8'h00, 8'h00, 8'h00, 8'h00, 1'b0},
        '{2'h1, 8'h81, 8'h3c, 8'h81, 8'h3c, 1'b1}};

    switch_model i_sw (.clk(clk), .pins(pinsIn));
    motion_input_supervisor #(.POS_W(32)) i_dut (.clk(clk), .sys_rst(sysRst),
        .address(address), .read(read), .write(write), .writedata(writedata),
        .readdata(readdata), .waitrequest(waitrequest), .irq(irq), .pinsIn(pinsIn),
        .axisPos(axisPos), .haltAll(haltAll), .programAbort(programAbort),
        .coreResetN(coreResetN), .fwdInhibit(fwdInhibit), .revInhibit(revInhibit),
        .limitRoutineStart(limitRoutineStart), .slewRequest(slewRequest),
        .homeStop(homeStop));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // Pulses are counted where they stand, one cycle each
    always @(posedge clk) begin
        if (programAbort === 1'b1) nAbort++;
        if (limitRoutineStart === 1'b1) nLim++;
        if (homeStop[0] === 1'b1) nHome++;
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic bus(input logic we, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        address <= a;
        writedata <= d;
        write <= we;
        read <= ~we;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (waitrequest !== 1'b0 && k < 50);
        rdat = readdata;
        write <= 1'b0;
        read <= 1'b0;
        if (k >= 50) err_count++;
    endtask
    task automatic settle();
        repeat (5) @(posedge clk);
    endtask
    function automatic logic [31:0] cmd(input logic [3:0] op, input logic [7:0] m);
        return {20'h0, op, m};
    endfunction
    function automatic logic [31:0] pos(input int i, input int d);
        return 32'h0100_0000 * (i + 1) + 32'h55 + d;
    endfunction
    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        tally_and_finish();
    end

    initial begin
        sysRst = 1'b1;
        read = 1'b0;
        write = 1'b0;
        address = '0;
        writedata = '0;
        for (int i = 0; i < AXES; i++) axisPos[i*32+:32] = pos(i, 0);
        repeat (20) @(posedge clk);
        sysRst <= 1'b0;
        @(posedge clk);
        check("waitrequest", waitrequest, 1);
        check("haltAll", haltAll, 0);
        check("coreResetN", coreResetN, 1);
        check("irq", irq, 0);
        bus(0, REG_CTRL, 0);
        check("ctrl", rdat, {30'h0, CTRL_RESET});
        bus(0, REG_POLARITY, 0);
        check("polarity", rdat, {30'h0, POL_RESET});
        bus(1, 8'h80, 32'hffff_ffff);
        bus(0, 8'h80, 0);
        check("unmapped", rdat, 0);
        p = PINS_RESET;
        foreach (rows[i]) begin
            nLim = 0;
            bus(1, REG_POLARITY, {30'h0, rows[i].pol});
            p.fwd = rows[i].fwd;
            p.rev = rows[i].rev;
            i_sw.set_pins(p);
            settle();
            check("fwdInhibit", fwdInhibit, rows[i].expF);
            check("revInhibit", revInhibit, rows[i].expR);
            bus(0, REG_SWITCHES, 0);
            check("switches", rdat[23:8], {rows[i].expR, rows[i].expF});
            if (rows[i].chkL) check("limitStart", 32'(nLim), 1);
        end
        p.fwd = '0;
        p.rev = '0;
        i_sw.set_pins(p);
        settle();
        bus(1, REG_IRQ_STATUS, 32'h1f);
        bus(0, REG_IRQ_STATUS, 0);
        check("irqStatus", rdat, 0);
        // Abort: level halt, one program abort pulse, masked then unmasked interrupt
        nAbort = 0;
        p.abortN = 1'b0;
        i_sw.set_pins(p);
        settle();
        check("haltAll", haltAll, 1);
        check("programAbort", 32'(nAbort), 1);
        bus(0, REG_IRQ_STATUS, 0);
        check("abortStatus", rdat[IRQ_ABORT], 1);
        check("irqMasked", irq, 0);
        bus(1, REG_IRQ_MASK, 32'h1);
        settle();
        check("irqUnmasked", irq, 1);
        p.abortN = 1'b1;
        i_sw.set_pins(p);
        settle();
        check("haltRelease", haltAll, 0);
        bus(1, REG_IRQ_STATUS, 32'h1);
        settle();
        check("irqCleared", irq, 0);
        // Homing on axis 0, find edge on axis 2, begin on axes 0 to 2; axis 1 never armed
        bus(1, REG_COMMAND, cmd(OP_HOMING, 8'h01));
        bus(1, REG_COMMAND, cmd(OP_FIND_EDGE, 8'h04));
        bus(1, REG_COMMAND, cmd(OP_BEGIN, 8'h07));
        settle();
        check("slewRequest", slewRequest, 8'h05);
        nHome = 0;
        p.home[0] = 1'b1;
        i_sw.set_pins(p);
        settle();
        check("homeStop", 32'(nHome), 1);
        check("slewStopped", slewRequest, 8'h04);
        bus(0, REG_IRQ_STATUS, 0);
        check("homeStatus", rdat[IRQ_HOME], 1);
        bus(0, REG_SWITCHES, 0);
        check("homeLow", rdat[31:24], 8'hfe);
        bus(1, REG_POLARITY, 32'h3);
        bus(0, REG_SWITCHES, 0);
        check("homeHigh", rdat[31:24], 8'h01);
        // General inputs, later reused as latch triggers
        p.gen = 16'ha5c3;
        i_sw.set_pins(p);
        settle();
        bus(0, REG_INPUTS, 0);
        check("inputs", rdat, 32'h0000_a5c3);
        bus(0, REG_IRQ_STATUS, 0);
        check("inputStatus", rdat[IRQ_INPUT], 1);
        // Armed but disabled: a trigger must leave the latch armed
        bus(1, REG_COMMAND, cmd(OP_ARM_LATCH, 8'h11));
        p.gen = 16'ha4c2;
        i_sw.set_pins(p);
        settle();
        bus(0, REG_LATCH_STATUS, 0);
        check("latchDisabled", rdat[15:0], 16'h1100);
        p.gen = 16'ha5c3;
        i_sw.set_pins(p);
        settle();
        bus(1, REG_CTRL, 32'h1);
        bus(1, REG_COMMAND, cmd(OP_ARM_LATCH, 8'h11));
        for (int n = 0; n < 2; n++) begin
            p.gen = 16'ha4c2;
            i_sw.set_pins(p);
            settle();
            bus(0, REG_LATCH_STATUS, 0);
            check("latchDone", rdat[7:0], 8'h11);
            bus(0, 8'h20, 0);
            check("latchAxis0", rdat, pos(0, 0));
            bus(0, 8'h30, 0);
            check("latchAxis4", rdat, pos(4, 0));
            // Second trigger with moved axes must leave the capture alone
            for (int i = 0; i < AXES; i++) axisPos[i*32+:32] <= pos(i, 7);
            p.gen = 16'ha5c3;
            i_sw.set_pins(p);
            settle();
        end
        // Pin reset restores the saved configuration and clears latches
        bus(1, REG_COMMAND, cmd(OP_SAVE, 8'h00));
        bus(1, REG_POLARITY, 32'h0);
        p.resetN = 1'b0;
        i_sw.set_pins(p);
        settle();
        check("coreResetN", coreResetN, 0);
        check("slewReset", slewRequest, 8'h00);
        p.resetN = 1'b1;
        i_sw.set_pins(p);
        settle();
        bus(0, REG_POLARITY, 0);
        check("polRestored", rdat, 32'h3);
        bus(0, REG_CTRL, 0);
        check("ctrlRestored", rdat, 32'h1);
        bus(0, REG_LATCH_STATUS, 0);
        check("latchCleared", rdat[7:0], 8'h00);
        // Power-on reset in mid-run returns readdata, irq, slew requests and polarity to reset values
        sysRst <= 1'b1;
        repeat (20) @(posedge clk);
        sysRst <= 1'b0;
        @(posedge clk);
        check("readdataRst", readdata, 0);
        check("irqRst", irq, 0);
        check("slewRst", slewRequest, 8'h00);
        bus(0, REG_POLARITY, 0);
        check("polRst", rdat, {30'h0, POL_RESET});
        tally_and_finish();
    end
endmodule
